// ==== design/isp_in_filter.sv ====
`timescale 1ns/1ps
module isp_in_filter
  import isp_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Pin and filter length
  input  wire logic       pin,
  input  wire logic [2:0] need,
  // Filtered level
  output logic            level
);
  logic       s1;
  logic       s2;
  logic       s3;
  logic [2:0] cnt;
  wire        agree   = (s2 == s3);
  wire        changed = agree && (s3 != level);
  wire        take    = changed && (cnt >= need);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Level must hold for need clocks before it is passed on
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt   <= 3'h0;
      level <= 1'b1;
    end else if (take) begin
      cnt   <= 3'h0;
      level <= s3;
    end else if (changed) begin
      cnt <= cnt + 3'h1;
    end else begin
      cnt <= 3'h0;
    end
  end
endmodule // isp_in_filter

// ==== design/isp_map.svh ====
`ifndef ISP_MAP_SVH
`define ISP_MAP_SVH

// Slave addresses, 8-bit form with the direction bit at zero
`define ISP_SADDR_00        8'ha0
`define ISP_SADDR_01        8'hb0
`define ISP_SADDR_10        8'hc0
`define ISP_SADDR_11        8'hd0
`define ISP_SADDR_SMALL     8'hd0

// Register offsets
`define ISP_OFS_BUS_CTRL    8'h0e
`define ISP_OFS_TIMEOUT     8'h10

// Field positions
`define ISP_GUARD_BIT       7
`define ISP_FILT_HI         3
`define ISP_FILT_LO         2
`define ISP_TOEN_BIT        7
`define ISP_TOF_BIT         6
`define ISP_TOS_HI          5
`define ISP_TOS_LO          0

// Reset values
`define ISP_RST_BYTE        8'h00

// Filter lengths in system clocks
`define ISP_FILT_NONE       3'h0
`define ISP_FILT_TWO        3'h2
`define ISP_FILT_FOUR       3'h4

// Timeout: sub clock divide and sub clocks per timeout unit
`define ISP_SUB_DIV         128
`define ISP_TO_SUB_PERIODS  32
`define ISP_TO_UNIT_CYCLES  (`ISP_SUB_DIV * `ISP_TO_SUB_PERIODS)

// Byte framing
`define ISP_BYTE_BITS       4'h8

`endif

// ==== design/isp_pkg.sv ====
package isp_pkg;
  `include "isp_map.svh"

  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_ADDR      = 3'b001,
    ST_ADDR_ACK  = 3'b010,
    ST_WRITE     = 3'b011,
    ST_WRITE_ACK = 3'b100,
    ST_READ      = 3'b101,
    ST_READ_ACK  = 3'b110
  } isp_state_t;

  function automatic logic [7:0] isp_own_addr(input logic small_pkg,
                                              input logic strap,
                                              input logic sel_hi,
                                              input logic sel_lo);
    logic [7:0] a;
    a = `ISP_SADDR_00;
    if (small_pkg)
      a = `ISP_SADDR_SMALL;
    else if (strap) begin
      case ({sel_hi, sel_lo})
        2'b00:   a = `ISP_SADDR_00;
        2'b01:   a = `ISP_SADDR_01;
        2'b10:   a = `ISP_SADDR_10;
        default: a = `ISP_SADDR_11;
      endcase
    end
    return a;
  endfunction
endpackage

// ==== design/isp_slave_port.sv ====
`timescale 1ns/1ps
module isp_slave_port
  import isp_pkg::*;
#(
  parameter bit SMALL_PKG    = 1'b0,
  parameter int SUB_DIV      = `ISP_SUB_DIV,
  parameter int TO_SUB_COUNT = `ISP_TO_SUB_PERIODS
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Serial bus
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  // Address straps
  input  wire logic       clock_source_strap,
  input  wire logic       osc_in_addr_sel_lo,
  input  wire logic       osc_out_addr_sel_hi,
  // Register port to the converter blocks
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_wr,
  input  wire logic [7:0] reg_rdata,
  // Control state
  output logic            mode_guard_bit
);
  if (SUB_DIV < 2 || SUB_DIV > 65536 || TO_SUB_COUNT < 1
      || TO_SUB_COUNT > 65536) begin : g_chk
    $error("isp_slave_port: divider parameters out of range");
  end

  isp_state_t state;
  logic       strap_done;
  logic [7:0] own_addr;
  logic [1:0] input_filter_select;
  logic       timeout_enable;
  logic       timeout_flag;
  logic [5:0] timeout_count_select;
  logic       scl_f;
  logic       sda_f;
  logic       scl_q;
  logic       sda_q;
  logic [7:0] shreg;
  logic [7:0] txreg;
  logic [3:0] bit_cnt;
  logic       rw;
  logic       have_ptr;
  logic       master_nack;
  logic [15:0] sub_cnt;
  logic [15:0] unit_cnt;
  logic [5:0]  to_cnt;

  // Filter length from select field
  wire [2:0] filt_need = (input_filter_select == 2'b00) ? `ISP_FILT_NONE :
                         (input_filter_select == 2'b01) ? `ISP_FILT_TWO :
                                                          `ISP_FILT_FOUR;

  isp_in_filter u_scl (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pin   (scl_in),
    .need  (filt_need),
    .level (scl_f)
  );

  isp_in_filter u_sda (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pin   (sda_in),
    .need  (filt_need),
    .level (sda_f)
  );

  // Bus events; slave only samples the clock
  wire scl_rise = scl_f && !scl_q;
  wire scl_fall = !scl_f && scl_q;
  wire start_ev = scl_f && scl_q && sda_q && !sda_f;
  wire stop_ev  = scl_f && scl_q && !sda_q && sda_f;
  wire byte_done = (bit_cnt == `ISP_BYTE_BITS);
  wire addr_hit  = (shreg[7:1] == own_addr[7:1]);

  // Register read view
  wire [7:0] ctrl_rd = {mode_guard_bit, 3'h0, input_filter_select,
                        2'h0};
  wire [7:0] to_rd   = {timeout_enable, timeout_flag,
                        timeout_count_select};
  wire [7:0] rd_byte = (reg_addr == `ISP_OFS_BUS_CTRL) ? ctrl_rd :
                       (reg_addr == `ISP_OFS_TIMEOUT)  ? to_rd :
                                                          reg_rdata;

  // Timeout dividers: sub clock enable, then unit enable
  wire sub_tick  = (sub_cnt == 16'(SUB_DIV - 1));
  wire unit_tick = sub_tick && (unit_cnt == 16'(TO_SUB_COUNT - 1));
  wire bus_busy  = (state != ST_IDLE);
  wire to_hit    = timeout_enable && bus_busy && unit_tick
                   && (to_cnt == timeout_count_select);
  wire wr_fire   = scl_fall && (state == ST_WRITE) && byte_done
                   && have_ptr;
  wire wr_ctrl   = wr_fire && (reg_addr == `ISP_OFS_BUS_CTRL);
  wire wr_to     = wr_fire && (reg_addr == `ISP_OFS_TIMEOUT);

  // Straps caught once after reset release
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strap_done <= 1'b0;
      own_addr   <= `ISP_SADDR_00;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      own_addr   <= isp_own_addr(SMALL_PKG, clock_source_strap,
                                 osc_out_addr_sel_hi,
                                 osc_in_addr_sel_lo);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  // Control and timeout registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_guard_bit       <= 1'b0;
      input_filter_select  <= 2'h0;
      timeout_enable       <= 1'b0;
      timeout_count_select <= 6'h0;
    end else begin
      if (wr_ctrl) begin
        mode_guard_bit      <= shreg[`ISP_GUARD_BIT];
        input_filter_select <= shreg[`ISP_FILT_HI:`ISP_FILT_LO];
      end
      if (wr_to) begin
        timeout_enable       <= shreg[`ISP_TOEN_BIT];
        timeout_count_select <= shreg[`ISP_TOS_HI:`ISP_TOS_LO];
      end
    end
  end

  // Sticky flag; a timeout in the clearing cycle wins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      timeout_flag <= 1'b0;
    else if (to_hit)
      timeout_flag <= 1'b1;
    else if (wr_to)
      timeout_flag <= timeout_flag & shreg[`ISP_TOF_BIT];
  end

  // Timeout counting restarts on every clock edge and when idle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sub_cnt  <= 16'h0000;
      unit_cnt <= 16'h0000;
      to_cnt   <= 6'h00;
    end else if (!bus_busy || scl_rise || scl_fall) begin
      sub_cnt  <= 16'h0000;
      unit_cnt <= 16'h0000;
      to_cnt   <= 6'h00;
    end else begin
      sub_cnt <= sub_tick ? 16'h0000 : sub_cnt + 16'h0001;
      if (sub_tick)
        unit_cnt <= unit_tick ? 16'h0000 : unit_cnt + 16'h0001;
      if (unit_tick)
        to_cnt <= to_cnt + 6'h01;
    end
  end

  // Receive side: sample on clock high
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shreg       <= `ISP_RST_BYTE;
      master_nack <= 1'b0;
    end else if (scl_rise) begin
      if (state == ST_ADDR || state == ST_WRITE)
        shreg <= {shreg[6:0], sda_f};
      if (state == ST_READ_ACK)
        master_nack <= sda_f;
    end
  end

  // Protocol sequencer; data line changes on clock fall, except release on start, stop or timeout
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      bit_cnt   <= 4'h0;
      rw        <= 1'b0;
      have_ptr  <= 1'b0;
      txreg     <= `ISP_RST_BYTE;
      sda_oe_n  <= 1'b1;
      sda_out   <= 1'b0;
      reg_addr  <= `ISP_RST_BYTE;
      reg_wdata <= `ISP_RST_BYTE;
      reg_wr    <= 1'b0;
    end else begin
      reg_wr <= 1'b0;
      // Pointer moves on only after the strobe has used it
      if (reg_wr)
        reg_addr <= reg_addr + 8'h01;
      if (start_ev) begin
        state    <= ST_ADDR;
        bit_cnt  <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (stop_ev || to_hit) begin
        state    <= ST_IDLE;
        sda_oe_n <= 1'b1;
      end else if (scl_rise && state != ST_READ
                   && state != ST_READ_ACK) begin
        bit_cnt <= bit_cnt + 4'h1;
      end else if (scl_rise && state == ST_READ_ACK && !sda_f) begin
        reg_addr <= reg_addr + 8'h01;
      end else if (scl_fall) begin
        unique case (state)
          ST_IDLE: ;
          ST_ADDR: if (byte_done) begin
            if (addr_hit) begin
              rw       <= shreg[0];
              sda_oe_n <= 1'b0;
              state    <= ST_ADDR_ACK;
            end else
              state <= ST_IDLE;
          end
          ST_ADDR_ACK: begin
            bit_cnt <= 4'h0;
            if (rw) begin
              txreg    <= {rd_byte[6:0], 1'b0};
              sda_oe_n <= rd_byte[7];
              state    <= ST_READ;
            end else begin
              sda_oe_n <= 1'b1;
              have_ptr <= 1'b0;
              state    <= ST_WRITE;
            end
          end
          ST_WRITE: if (byte_done) begin
            if (have_ptr) begin
              reg_wdata <= shreg;
              reg_wr    <= 1'b1;
            end else
              reg_addr <= shreg;
            have_ptr <= 1'b1;
            sda_oe_n <= 1'b0;
            state    <= ST_WRITE_ACK;
          end
          ST_WRITE_ACK: begin
            sda_oe_n <= 1'b1;
            bit_cnt  <= 4'h0;
            state    <= ST_WRITE;
          end
          ST_READ: begin
            if (bit_cnt == 4'h7) begin
              sda_oe_n <= 1'b1;
              state    <= ST_READ_ACK;
            end else begin
              sda_oe_n <= txreg[7];
              txreg    <= {txreg[6:0], 1'b0};
            end
            bit_cnt <= bit_cnt + 4'h1;
          end
          ST_READ_ACK: if (master_nack) begin
            sda_oe_n <= 1'b1;
            state    <= ST_IDLE;
          end else begin
            // Next byte's first bit goes out on this same fall
            txreg    <= {rd_byte[6:0], 1'b0};
            sda_oe_n <= rd_byte[7];
            bit_cnt  <= 4'h0;
            state    <= ST_READ;
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // isp_slave_port

// ==== testbench/isp_bus_master.sv ====
`timescale 1ns/1ps
module isp_bus_master #(
  parameter int Q = 16
) (
  // Clock
  input  wire logic mclk,
  // Bus lines
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wq(input logic c, input logic d);
    scl     <= c;
    sda_low <= d;
    repeat (Q) @(posedge mclk);
  endtask

  task automatic start();
    wq(1'b0, sda_low);
    wq(1'b0, 1'b0);
    wq(1'b1, 1'b0);
    wq(1'b1, 1'b1);
  endtask

  task automatic stop();
    wq(1'b0, sda_low);
    wq(1'b0, 1'b1);
    wq(1'b1, 1'b1);
    wq(1'b1, 1'b0);
  endtask

  // Data moves only with clock low
  task automatic bit_x(input logic b, output logic r);
    wq(1'b0, sda_low);
    wq(1'b0, !b);
    wq(1'b1, !b);
    r = sda;
    wq(1'b1, !b);
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, ack);
  endtask

  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(nack, r);
  endtask
endmodule // isp_bus_master

// ==== testbench/isp_slave_port_monitor.sv ====
`timescale 1ns/1ps
module isp_slave_port_monitor (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst_n,
  // Bus pins
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       mode_guard_bit
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  AST_OPEN_DRAIN: assert property (sda_out == 1'b0)
    else $error("data drive value not low");
  AST_HOLD_CLK_HIGH: assert property (
    scl_in && $past(scl_in) |-> $stable(sda_oe_n))
    else $error("data drive moved while clock high");
  AST_PULL_CLK_LOW: assert property (
    $fell(sda_oe_n) |-> !scl_in)
    else $error("data pulled low while clock high");
  AST_STOP_IDLE: assert property (
    scl_in && $rose(sda_in) |=> sda_oe_n [*8])
    else $error("data driven after stop");
  AST_WR_PULSE: assert property (reg_wr |=> !reg_wr)
    else $error("write strobe longer than one cycle");
  AST_WR_INCR: assert property (
    reg_wr |=> reg_addr == $past(reg_addr) + 8'h01)
    else $error("pointer not advanced after write");
  AST_WDATA_SRC: assert property (
    $changed(reg_wdata) |-> reg_wr)
    else $error("write data changed without strobe");
  AST_GUARD_SRC: assert property (
    $changed(mode_guard_bit) |-> reg_wr && reg_addr == 8'h0e)
    else $error("guard bit changed without write");

  COV_WRITE: cover property (reg_wr);
  COV_DRIVE: cover property ($fell(sda_oe_n));
  COV_CTRL: cover property (reg_wr && reg_addr == 8'h0e);
endmodule // isp_slave_port_monitor

bind isp_slave_port isp_slave_port_monitor u_mon (
  .mclk, .rst_n, .scl_in, .sda_in, .sda_out, .sda_oe_n,
  .reg_addr, .reg_wdata, .reg_wr, .mode_guard_bit
);

// ==== testbench/tb_isp_slave_port.sv ====
`timescale 1ns/1ps
module tb_isp_slave_port;
  logic        mclk, rst_n, scl, mst_low, sda, strap, sel_lo, sel_hi;
  logic        sda_out, sda_oe_n, reg_wr, mode_guard_bit, ak;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, wa, wd, b;
  logic [11:0] rows [7];
  int          err_count, n_checks;

  assign sda       = !(mst_low || (!sda_oe_n && !sda_out));
  assign reg_rdata = ~reg_addr;

  isp_slave_port #(.SUB_DIV(4), .TO_SUB_COUNT(2)) u_dut (
    .mclk, .rst_n, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe_n,
    .clock_source_strap(strap), .osc_in_addr_sel_lo(sel_lo),
    .osc_out_addr_sel_hi(sel_hi), .reg_addr, .reg_wdata, .reg_wr,
    .reg_rdata, .mode_guard_bit);

  isp_bus_master u_mst (.mclk, .sda, .scl, .sda_low(mst_low));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk) if (reg_wr) begin
    wa <= reg_addr;
    wd <= reg_wdata;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic do_reset(input logic s, input logic h, input logic l);
    @(posedge mclk);
    rst_n  <= 1'b0;
    strap  <= s;
    sel_hi <= h;
    sel_lo <= l;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (10) @(posedge mclk);
  endtask

  task automatic send(input logic [7:0] d);
    u_mst.wbyte(d, ak);
    chk({7'h0, ak}, 8'h00);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    u_mst.start();
    send(8'ha0);
    send(a);
    send(d);
    u_mst.stop();
  endtask

  task automatic rd_start(input logic [7:0] a);
    u_mst.start();
    send(8'ha0);
    send(a);
    u_mst.start();
    send(8'ha1);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    rd_start(a);
    u_mst.rbyte(1'b1, b);
    chk(b, exp);
    u_mst.stop();
  endtask

  initial begin
    repeat (100000) @(posedge mclk);
    err_count++;
    report_and_stop();
  end

  initial begin
    rst_n = 1'b0;
    strap = 1'b0;
    sel_hi = 1'b0;
    sel_lo = 1'b0;
    err_count = 0;
    n_checks = 0;
    // Strap, high select, low select, nack, address
    rows = '{12'h6a0, 12'h7d0, 12'h8a0, 12'hab0, 12'hcc0, 12'hed0, 12'hba0};
    foreach (rows[i]) begin
      do_reset(rows[i][11], rows[i][10], rows[i][9]);
      u_mst.start();
      u_mst.wbyte(rows[i][7:0], ak);
      chk({7'h0, ak}, {7'h0, rows[i][8]});
      u_mst.stop();
    end
    do_reset(1'b0, 1'b0, 1'b0);
    chk({7'h0, mode_guard_bit}, 8'h00);
    rd_chk(8'h0e, 8'h00);
    for (int f = 0; f < 4; f++) begin
      wr_reg(8'h0e, {4'h7, f[1:0], 2'h3});
      rd_chk(8'h0e, {4'h0, f[1:0], 2'h0});
    end
    wr_reg(8'h05, 8'h5a);
    chk(wa, 8'h05);
    chk(wd, 8'h5a);
    rd_start(8'h05);
    u_mst.rbyte(1'b0, b);
    chk(b, 8'hfa);
    u_mst.rbyte(1'b1, b);
    chk(b, 8'hf9);
    // Line must float high after the nack
    u_mst.rbyte(1'b1, b);
    chk(b, 8'hff);
    u_mst.stop();
    wr_reg(8'h10, 8'h87);
    // Stall with the device pulling its address acknowledge
    u_mst.start();
    b = 8'ha0;
    for (int i = 7; i >= 0; i--) u_mst.bit_x(b[i], ak);
    u_mst.wq(1'b0, 1'b0);
    chk({7'h0, sda_oe_n}, 8'h00);
    repeat (200) @(posedge mclk);
    chk({7'h0, sda_oe_n}, 8'h01);
    u_mst.stop();
    rd_chk(8'h10, 8'hc7);
    wr_reg(8'h10, 8'h07);
    rd_chk(8'h10, 8'h07);
    wr_reg(8'h0e, 8'h80);
    chk({7'h0, mode_guard_bit}, 8'h01);
    // Mid-run reset brings the guard bit back to zero
    do_reset(1'b0, 1'b0, 1'b0);
    chk({7'h0, mode_guard_bit}, 8'h00);
    rd_chk(8'h0e, 8'h00);
    report_and_stop();
  end
endmodule // tb_isp_slave_port
